/* bench/fault_host.sv */
// host model: holds the fault-response and unit settings, sends clears
`default_nettype none
module fault_host (
  // clock
  input wire logic clk,
  // settings and clear event
  output fault_retry_pkg::retry_cfg_s cfg,
  output logic clear_faults
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg = '0;
    clear_faults = 1'b0;
  end
  // new settings land off the sampling edge; callers keep units short
  task automatic load_cfg(input logic [7:0] resp,
      input logic [fault_retry_pkg::UNIT_W-1:0] unit);
    @(negedge clk);
    cfg.response = resp;
    cfg.unit_cycles = unit;
  endtask
  // one-cycle clear pulse, driven off the sampling edge
  task automatic clear();
    @(negedge clk);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
  endtask
endmodule // fault_host
`default_nettype wire

/* bench/fault_retry_sequencer_bench.sv */
// self-checking bench for the fault restart sequencer
`default_nettype none
module fault_retry_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic fault = 1'b0;
  logic cmd_off = 1'b0;
  logic other_shutdown = 1'b0;
  logic restart_ok = 1'b0;
  fault_retry_pkg::retry_cfg_s cfg;
  logic clear_faults;
  fault_retry_pkg::retry_stat_s stat;
  int n_errors = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  fault_host host (.clk(clk), .cfg(cfg), .clear_faults(clear_faults));
  fault_retry_sequencer uut (.clk(clk), .reset(reset), .cfg(cfg),
    .fault(fault), .restart_ok(restart_ok), .clear_faults(clear_faults),
    .cmd_off(cmd_off), .other_shutdown(other_shutdown), .stat(stat));
  // compare and count
  task automatic chk(input string what, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", what, e, g);
    end
  endtask
  // fault with response 10, then count attempts and their spacing
  task automatic t_counted(input logic [2:0] r, input logic [2:0] d,
      input logic [15:0] u);
    int i;
    int last;
    int n;
    host.load_cfg({2'h2, r, d}, u);
    @(negedge clk);
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    last = 1;
    n = 0;
    for (i = 1; i < 2000 && stat.latched_off !== 1'b1; i++) begin
      if (i == 1) chk("oe off", 0, stat.output_enable);
      if (stat.restart_pulse === 1'b1) begin
        n++;
        chk("spacing", int'(u) << d, i - last);
        last = i;
      end
      @(negedge clk);
    end
    chk("attempts", r, n);
    chk("attempts made", r, stat.attempts_made);
    chk("latched", 1, stat.latched_off);
    repeat (20) @(negedge clk);
    chk("stays off", 0, stat.output_enable);
    host.clear();
    @(negedge clk);
    chk("on again", 1, stat.output_enable);
  endtask
  // retry 000: latched at once, never a pulse
  task automatic t_none();
    host.load_cfg({2'h2, 3'h0, 3'h0}, 16'h0002);
    @(negedge clk);
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    @(negedge clk);
    chk("latched now", 1, stat.latched_off);
    chk("none oe off", 0, stat.output_enable);
    repeat (10) @(negedge clk);
    chk("no attempt", 0, stat.attempts_made);
    host.clear();
  endtask
  // retry 111: never latches until commanded off or another shutdown
  task automatic t_forever(input logic sel);
    int n;
    host.load_cfg({2'h2, 3'h7, 3'h0}, 16'h0002);
    @(negedge clk);
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (stat.restart_pulse === 1'b1) n++;
      if (stat.latched_off !== 1'b0) n = -100;
    end
    chk("endless", 20, n);
    if (sel) other_shutdown = 1'b1;
    else cmd_off = 1'b1;
    @(negedge clk);
    other_shutdown = 1'b0;
    cmd_off = 1'b0;
    @(negedge clk);
    chk("stopped", 1, stat.latched_off);
    host.clear();
  endtask
  // a good attempt returns to running and ends the retries
  task automatic t_recover();
    int n;
    host.load_cfg({2'h2, 3'h3, 3'h1}, 16'h0002);
    @(negedge clk);
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    n = 0;
    while (n < 50 && stat.restart_pulse !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk("first attempt", 1, stat.restart_pulse);
    restart_ok = 1'b1;
    @(negedge clk);
    restart_ok = 1'b0;
    n = 0;
    repeat (30) begin
      @(negedge clk);
      if (stat.restart_pulse === 1'b1 || stat.output_enable !== 1'b1) n++;
    end
    chk("recovered", 0, n);
    chk("not latched", 0, stat.latched_off);
    host.clear();
  endtask
  // response 11, not disable-and-retry, leaves the output alone
  task automatic t_other_resp();
    host.load_cfg({2'h3, 3'h2, 3'h0}, 16'h0002);
    @(negedge clk);
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    repeat (10) @(negedge clk);
    chk("ignored oe", 1, stat.output_enable);
    chk("ignored latch", 0, stat.latched_off);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    chk("reset oe", 1, stat.output_enable);
    for (int r = 1; r < 7; r++) t_counted(3'(r), 3'(r), 16'h0002);
    t_counted(3'h2, 3'h7, 16'h0002);
    t_counted(3'h2, 3'h0, 16'h0002);
    t_counted(3'h3, 3'h1, 16'h0005);
    t_none();
    t_recover();
    t_other_resp();
    t_forever(1'b0);
    t_forever(1'b1);
    final_report();
  end
  initial begin
    #600000;
    n_errors++;
    final_report();
  end
endmodule // fault_retry_sequencer_bench
`default_nettype wire

/* rtl/fault_retry_pkg.sv */
// constants and carrier types for the fault restart sequencer
`default_nettype none
package fault_retry_pkg;
  // ------------------------------------------------------------
  // fault-response byte layout
  // ------------------------------------------------------------
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  // ------------------------------------------------------------
  // encodings and widths
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int UNIT_W = 16;
  localparam int DELAY_W = UNIT_W + 7;
  localparam logic [7:0] RESP_RESET = 8'h00;

  // host configuration
  typedef struct packed {
    logic [7:0] response;
    logic [UNIT_W-1:0] unit_cycles;
  } retry_cfg_s;

  // sequencer status
  typedef struct packed {
    logic output_enable;
    logic latched_off;
    logic restart_pulse;
    logic [2:0] attempts_made;
  } retry_stat_s;
endpackage
`default_nettype wire

/* rtl/fault_retry_sequencer.sv */
// fault restart sequencer: attempt count and restart spacing
// Operation
// - retry field 2..6 gives exactly that many restart attempts
// - all attempts failed: output stays off until fault cleared
// - spacing between attempt starts is delay count times time unit
// - retry 111 restarts forever until off, bias loss or other fault
// - delay field selects two to the power of its value units
// - delay count serves as run time after fault or retry spacing; here only as retry spacing, never as run time
// - time unit length comes from a separate unit register
// - retry 000 makes no attempt; output off until cleared
// - retry 001 makes one attempt, then off until cleared
// - fault cleared by clear command, bit clear, off-on, bias loss; here only clear_faults clears, cmd_off and other_shutdown latch off
// - response 10 shuts down at once then follows retry setting
`default_nettype none
module fault_retry_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire fault_retry_pkg::retry_cfg_s cfg,
  // fault and clearing events
  input wire logic fault,
  input wire logic restart_ok,
  input wire logic clear_faults,
  input wire logic cmd_off,
  input wire logic other_shutdown,
  // status
  output fault_retry_pkg::retry_stat_s stat
);
  // ------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {RUN, WAIT, TRY, LATCH} state_e;
  localparam int DW = fault_retry_pkg::DELAY_W;

  // delay in cycles: 2**field units of unit_cycles each
  function automatic logic [DW-1:0] delay_cycles(
      input logic [2:0] field,
      input logic [fault_retry_pkg::UNIT_W-1:0] unit);
    logic [DW-1:0] u;
    u = DW'(unit);
    return u << field;
  endfunction

  state_e state, next_state;
  logic [DW-1:0] timer, next_timer;
  logic [2:0] tries, next_tries;
  logic oe, next_oe, pulse, next_pulse;
  logic [2:0] retry_set, dly;
  logic [1:0] resp;

  // fields of the fault-response byte
  assign resp = cfg.response[fault_retry_pkg::RESP_MSB:
                             fault_retry_pkg::RESP_LSB];
  assign retry_set = cfg.response[fault_retry_pkg::RETRY_MSB:
                                  fault_retry_pkg::RETRY_LSB];
  assign dly = cfg.response[fault_retry_pkg::DELAY_MSB:
                            fault_retry_pkg::DELAY_LSB];

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_tries = tries;
    next_oe = oe;
    next_pulse = 1'b0;
    case (state)
      RUN: begin
        next_oe = 1'b1;
        if (fault && resp == fault_retry_pkg::RESP_DISABLE_RETRY) begin
          next_oe = 1'b0;
          next_tries = 3'h0;
          if (retry_set == fault_retry_pkg::RETRY_NONE) begin
            next_state = LATCH;
          end else begin
            next_state = WAIT;
            next_timer = delay_cycles(dly, cfg.unit_cycles);
          end
        end
      end
      WAIT: begin
        next_oe = 1'b0;
        if (timer <= DW'(1)) begin
          next_state = TRY;
          next_oe = 1'b1;
          next_pulse = 1'b1;
          if (tries != 3'h7) begin
            next_tries = tries + 3'h1;
          end
          next_timer = delay_cycles(dly, cfg.unit_cycles);
        end else begin
          next_timer = timer - DW'(1);
        end
      end
      TRY: begin
        next_oe = 1'b1;
        if (restart_ok) begin
          next_state = RUN;
        end else if (timer <= DW'(1)) begin
          // attempt failed; next attempt start one delay later
          if (retry_set != fault_retry_pkg::RETRY_FOREVER &&
              tries >= retry_set) begin
            next_state = LATCH;
            next_oe = 1'b0;
          end else begin
            next_state = TRY;
            next_pulse = 1'b1;
            if (tries != 3'h7) begin
              next_tries = tries + 3'h1;
            end
            next_timer = delay_cycles(dly, cfg.unit_cycles);
          end
        end else begin
          next_timer = timer - DW'(1);
        end
      end
      LATCH: begin
        next_oe = 1'b0;
      end
      default: begin
        next_state = LATCH;
        next_oe = 1'b0;
      end
    endcase
    // clearing overrides everything except command off and other shutdown, which win
    if (clear_faults) begin
      next_state = RUN;
      next_oe = 1'b1;
      next_tries = 3'h0;
      next_pulse = 1'b0;
    end
    if (cmd_off || other_shutdown) begin
      next_state = LATCH;
      next_oe = 1'b0;
      next_pulse = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= RUN;
      timer <= '0;
      tries <= 3'h0;
      oe <= 1'b1;
      pulse <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      tries <= next_tries;
      oe <= next_oe;
      pulse <= next_pulse;
    end
  end

  // status word straight from the registers
  assign stat.output_enable = oe;
  assign stat.latched_off = (state == LATCH);
  assign stat.restart_pulse = pulse;
  assign stat.attempts_made = tries;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // latched off keeps the output dark until a clear
  a_latch_holds_off: assert property (@(posedge clk) disable iff (reset)
    state == LATCH && !clear_faults |=> !oe)
    else $error("output enabled while latched off");
  a_latch_dark: assert property (@(posedge clk) disable iff (reset)
    state == LATCH |-> !oe)
    else $error("output on in latched state");
  // attempt count never passes the retry setting
  a_attempt_limit: assert property (@(posedge clk) disable iff (reset)
    retry_set != fault_retry_pkg::RETRY_FOREVER && state != LATCH
      |-> tries <= retry_set || retry_set == 3'h0)
    else $error("more attempts than retry setting");
  a_none_no_try: assert property (@(posedge clk) disable iff (reset)
    state == RUN && fault && !clear_faults && !cmd_off &&
    !other_shutdown && resp == fault_retry_pkg::RESP_DISABLE_RETRY &&
    retry_set == 3'h0 |=> state == LATCH && !oe)
    else $error("retry none did not latch");
  a_once_latch: assert property (@(posedge clk) disable iff (reset)
    state == TRY && retry_set == 3'h1 && tries == 3'h1 &&
    timer <= 1 && !restart_ok && !clear_faults |=> state == LATCH)
    else $error("single retry did not latch");
  // a taken fault darkens the output at once and keeps it off while waiting
  a_shutdown_now: assert property (@(posedge clk) disable iff (reset)
    state == RUN && fault && !clear_faults &&
    resp == fault_retry_pkg::RESP_DISABLE_RETRY |=> !oe)
    else $error("output not shut down on fault");
  a_wait_dark: assert property (@(posedge clk) disable iff (reset)
    state == WAIT |-> !oe)
    else $error("output on while waiting to retry");
  // every attempt starts with the output on and a fresh spacing count
  a_first_attempt: assert property (@(posedge clk) disable iff (reset)
    state == WAIT && timer <= DW'(1) && !clear_faults && !cmd_off &&
    !other_shutdown |=> state == TRY && pulse)
    else $error("first attempt did not start");
  a_pulse_lit: assert property (@(posedge clk) disable iff (reset)
    pulse |-> oe && state == TRY)
    else $error("attempt start without output on");
  a_spacing_load: assert property (@(posedge clk) disable iff (reset)
    pulse |-> timer == delay_cycles(dly, cfg.unit_cycles)
      || $changed(cfg))
    else $error("retry spacing not loaded");
  // endless retry never latches on its own
  a_forever_keeps: assert property (@(posedge clk) disable iff (reset)
    state == TRY && retry_set == fault_retry_pkg::RETRY_FOREVER &&
    !restart_ok && !clear_faults && !cmd_off && !other_shutdown
      |=> state == TRY)
    else $error("endless retry stopped");
  a_success_run: assert property (@(posedge clk) disable iff (reset)
    state == TRY && restart_ok && !clear_faults && !cmd_off &&
    !other_shutdown |=> state == RUN && oe)
    else $error("good restart did not resume running");
  // clearing and commanding off
  a_clear_restores: assert property (@(posedge clk) disable iff (reset)
    clear_faults && !cmd_off && !other_shutdown |=> oe && tries == 0)
    else $error("clear did not restore output");
  a_off_stops: assert property (@(posedge clk) disable iff (reset)
    cmd_off |=> state == LATCH && !pulse)
    else $error("command off did not stop retries");
endmodule // fault_retry_sequencer
`default_nettype wire
